// >>> tcfc_pkg.sv
// Function
// - Edge field selects off, rising, falling, both
// - Channel flag interrupts gated by matching enable
// - Overflow flag interrupts only when overflow enabled
// - Channel 7 match resets counter when enabled
// - Compare value zero holds counter at zero
// - All-ones compare reset never sets overflow
// - New prescale applies when prescale counter zero
// - Capture or compare event sets channel flag
// - Write one clears flag, zero keeps it
// - Write-one flag clear needs timer or accumulator enable
// - Fast clear by channel register access
// - Fast clear overflow on any counter access
// - Counter rollover sets overflow flag
// - Prescale select only in legacy timer mode
// - Accumulator enable independent of timer enable
package tcfc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SYS_CTL    = 6'h06; // Timer system control, after the counter bytes
  localparam logic [5:0] IDX_CNT_HI     = 6'h04; // Counter high byte
  localparam logic [5:0] IDX_CNT_LO     = 6'h05; // Counter low byte
  localparam logic [5:0] IDX_EDGE_UP    = 6'h0a; // Channels 7..4 edge fields
  localparam logic [5:0] IDX_EDGE_LO    = 6'h0b; // Channels 3..0 edge fields
  localparam logic [5:0] IDX_CH_IE      = 6'h0c; // Channel interrupt enable
  localparam logic [5:0] IDX_PRE_CTL    = 6'h0d; // Prescale and overflow control
  localparam logic [5:0] IDX_CH_FLAG    = 6'h0e; // Channel flag status
  localparam logic [5:0] IDX_OVF_FLAG   = 6'h0f; // Overflow flag status
  localparam logic [5:0] IDX_CH_FIRST   = 6'h10; // First channel register
  localparam logic [5:0] IDX_CH_LAST    = 6'h1f; // Last channel register
  localparam logic [5:0] IDX_ACC_CTL    = 6'h20; // Accumulator control
  localparam logic [5:0] IDX_IRQ_STAT   = 6'h24; // Event status, read only
  localparam logic [5:0] IDX_IRQ_CLR    = 6'h25; // Event clear, write only
  localparam logic [5:0] IDX_IRQ_EN     = 6'h26; // Event enable
  // Field positions
  localparam int BIT_TEN       = 7; // Timer enable in system control
  localparam int BIT_FFCA      = 4; // Fast flag clear all
  localparam int BIT_PRECISION_TIMER_SELECT      = 3; // Precision timer select
  localparam int BIT_TOI       = 7; // Overflow interrupt enable
  localparam int BIT_COUNTER_RESET_ON_MATCH_ENABLE      = 3; // Counter reset on match enable
  localparam int BIT_OVF       = 7; // Overflow flag position
  localparam int BIT_ACCUMULATOR_ENABLE_BIT      = 6; // Accumulator enable
  localparam int EV_OVF        = 0; // Event: counter rollover
  localparam int EV_CAP        = 1; // Event: any capture
  localparam int EV_CMP        = 2; // Event: any compare
  localparam int EV_RST        = 3; // Event: counter reset by match
  // Reset values and constants
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [6:0]  PRE_ZERO   = 7'h00;
  localparam logic [2:0]  PRE_SEL_RST = 3'h0;
  localparam logic [3:0]  EV_ZERO    = 4'h0;
endpackage

// >>> tcfc_timer.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module tcfc_timer #(
  parameter int NCH = 8 // Number of channels
) (
  input  wire logic              clk_i,           // 50 MHz bus clock
  input  wire logic              rst_i,           // Synchronous reset
  input  wire logic              cyc_i,           // Wishbone cycle
  input  wire logic              stb_i,           // Wishbone strobe
  input  wire logic              we_i,            // Wishbone write
  input  wire logic [7:0]        adr_i,           // Byte address
  input  wire logic [3:0]        sel_i,           // Byte lanes
  input  wire logic [31:0]       dat_i,           // Write data
  output logic      [31:0]       dat_o,           // Read data
  output logic                   ack_o,           // Wishbone ack
  input  wire logic [NCH-1:0]    cap_pin_i,       // Capture pins
  input  wire logic [NCH-1:0]    chan_is_capture_i, // Channel in capture mode
  input  wire logic [NCH-1:0]    compare_event_i, // Successful compares
  input  wire logic [15:0]       ch7_compare_i,   // Channel 7 compare value
  input  wire logic              precision_tick_i, // Tick in precision mode
  output logic [NCH-1:0]         capture_event_o, // Capture strobes
  output logic [15:0]            counter_o,       // Free running counter
  output logic                   timer_enable_o,  // Timer enable bit
  output logic                   acc_enable_o,    // Accumulator enable bit
  output logic                   irq_o            // Level interrupt
);
  import tcfc_pkg::*;

  // Whole block state
  typedef struct packed {
    logic            ack;        // Bus answer
    logic [7:0]      rdata;      // Read data byte
    logic [15:0]     edge_cfg;   // {upper, lower} edge fields
    logic [7:0]      ch_ie;      // Channel interrupt enables
    logic [7:0]      pre_ctl;    // Prescale and overflow control
    logic            timer_enable_bit;        // Timer enable bit
    logic            ffca;       // Fast flag clear all
    logic            precision_timer_select;       // Precision timer select
    logic            precision_timer_select_done;  // Precision select written once
    logic            accumulator_enable_bit;       // Accumulator enable bit
    logic [7:0]      ch_flag;    // Channel flags
    logic            ovf_flag;   // Overflow flag
    logic [6:0]      pre_cnt;    // Prescale counter stages
    logic [2:0]      pre_sel;    // Active prescale select
    logic [15:0]     counter;    // Free running counter
    logic [7:0]      pin_prev;   // Previous pin samples
    logic [7:0]      cap_evt;    // Capture strobes
    logic [3:0]      ev_stat;    // Sticky event status
    logic [3:0]      ev_en;      // Event enables
    logic            irq;        // Interrupt level
  } tcfc_state_t;

  tcfc_state_t s_reg;  // Current state
  tcfc_state_t s_next; // Next state

  // Edge detect for one channel by its two-bit field
  function automatic logic tcfc_edge_hit(input logic [1:0] cfg, input logic prev, input logic now);
    tcfc_edge_hit = (cfg[0] & ~prev & now) | (cfg[1] & prev & ~now);
  endfunction

  // Bus decode
  logic       bus_req;     // Request pending, not yet answered
  logic       bus_do;      // Request completes at this edge
  logic       wr_do;       // Write takes effect
  logic       rd_do;       // Read takes effect
  logic [5:0] idx;         // Register index
  logic [7:0] wbyte;       // Written byte
  logic       wlane;       // Low lane selected
  logic       ch_acc;      // Access to a channel register
  logic [2:0] ch_num;      // Channel addressed
  logic       cnt_acc;     // Access to the counter
  logic       clr_ok;      // Flag clearing permitted
  logic [7:0] ch_set;      // Channel flag set sources
  logic [7:0] ch_clr;      // Channel flag clear sources
  logic       ovf_set;     // Overflow set source
  logic       ovf_clr;     // Overflow clear source
  logic       tick;        // Prescaled counter tick
  logic       ch7_match;   // Counter equals channel 7 compare
  logic       match_rst;   // Counter reset by match
  logic [6:0] pre_mask;    // Stages used by active select
  logic [7:0] cap_now;     // Capture edges this cycle
  logic [3:0] ev_in;       // Event sources

  assign bus_req = cyc_i & stb_i & ~s_reg.ack;
  assign bus_do  = cyc_i & stb_i & s_reg.ack;
  assign idx     = adr_i[7:2];
  assign wlane   = sel_i[0];
  assign wbyte   = dat_i[7:0];
  assign wr_do   = bus_do & we_i & wlane;
  assign rd_do   = bus_do & ~we_i;

  // Channel and counter access decode
  assign ch_acc  = (idx >= IDX_CH_FIRST) && (idx <= IDX_CH_LAST);
  assign ch_num  = idx[3:1];
  assign cnt_acc = bus_do && ((idx == IDX_CNT_HI) || (idx == IDX_CNT_LO));

  // Clearing works with either enable; the two bits are kept apart
  assign clr_ok = s_reg.timer_enable_bit | s_reg.accumulator_enable_bit;

  // Prescaler: divide by two to the select
  assign pre_mask = 7'(({7'h00, 1'b1} << s_reg.pre_sel) - 8'h01);
  assign tick = s_reg.precision_timer_select ? precision_tick_i
                           : ((s_reg.pre_cnt & pre_mask) == pre_mask);

  // Channel 7 match and counter reset
  assign ch7_match = (s_reg.counter == ch7_compare_i);
  assign match_rst = s_reg.pre_ctl[BIT_COUNTER_RESET_ON_MATCH_ENABLE] & ch7_match;

  // Capture edges per channel, gated by timer enable and capture mode
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_edge
      assign cap_now[g] = s_reg.timer_enable_bit & chan_is_capture_i[g]
                        & tcfc_edge_hit(s_reg.edge_cfg[2*g+1 -: 2], s_reg.pin_prev[g], cap_pin_i[g]);
    end
  endgenerate

  // Flag set and clear sources
  always_comb begin
    ch_set  = cap_now | compare_event_i;
    ch_clr  = 8'h00;
    if (wr_do && idx == IDX_CH_FLAG && clr_ok) begin
      ch_clr = wbyte;
    end
    if (s_reg.ffca && bus_do && ch_acc) begin
      // Read of a capture or write of a compare channel
      if (chan_is_capture_i[ch_num] ? ~we_i : we_i) begin
        ch_clr[ch_num] = 1'b1;
      end
    end
    ovf_set = s_reg.timer_enable_bit & tick & (s_reg.counter == CNT_MAX) & ~match_rst;
    ovf_clr = (wr_do && idx == IDX_OVF_FLAG && clr_ok && wbyte[BIT_OVF])
            | (s_reg.ffca & cnt_acc);
    ev_in = EV_ZERO;
    ev_in[EV_OVF] = ovf_set;
    ev_in[EV_CAP] = |cap_now;
    ev_in[EV_CMP] = |compare_event_i;
    ev_in[EV_RST] = s_reg.timer_enable_bit & tick & match_rst;
  end

  // Next state
  always_comb begin
    s_next = s_reg;
    // Single cycle ack with registered read data
    s_next.ack   = bus_req;
    s_next.rdata = RST_BYTE;
    if (bus_req && !we_i) begin
      case (idx)
        IDX_SYS_CTL: begin
          s_next.rdata[BIT_TEN]  = s_reg.timer_enable_bit;
          s_next.rdata[BIT_FFCA] = s_reg.ffca;
          s_next.rdata[BIT_PRECISION_TIMER_SELECT] = s_reg.precision_timer_select;
        end
        IDX_CNT_HI:   s_next.rdata = s_reg.counter[15:8];
        IDX_CNT_LO:   s_next.rdata = s_reg.counter[7:0];
        IDX_EDGE_UP:  s_next.rdata = s_reg.edge_cfg[15:8];
        IDX_EDGE_LO:  s_next.rdata = s_reg.edge_cfg[7:0];
        IDX_CH_IE:    s_next.rdata = s_reg.ch_ie;
        IDX_PRE_CTL:  s_next.rdata = s_reg.pre_ctl;
        IDX_CH_FLAG:  s_next.rdata = s_reg.ch_flag;
        IDX_OVF_FLAG: s_next.rdata[BIT_OVF] = s_reg.ovf_flag;
        IDX_ACC_CTL:  s_next.rdata[BIT_ACCUMULATOR_ENABLE_BIT] = s_reg.accumulator_enable_bit;
        IDX_IRQ_STAT: s_next.rdata = {4'h0, s_reg.ev_stat};
        IDX_IRQ_EN:   s_next.rdata = {4'h0, s_reg.ev_en};
        default:      s_next.rdata = RST_BYTE; // Unmapped and channel regs read zero
      endcase
    end
    // Register writes at the ack edge
    if (wr_do) begin
      case (idx)
        IDX_SYS_CTL: begin
          s_next.timer_enable_bit  = wbyte[BIT_TEN];
          s_next.ffca = wbyte[BIT_FFCA];
          // Precision select writable once after reset
          if (!s_reg.precision_timer_select_done) begin
            s_next.precision_timer_select      = wbyte[BIT_PRECISION_TIMER_SELECT];
            s_next.precision_timer_select_done = 1'b1;
          end
        end
        IDX_EDGE_UP: s_next.edge_cfg[15:8] = wbyte;
        IDX_EDGE_LO: s_next.edge_cfg[7:0]  = wbyte;
        IDX_CH_IE:   s_next.ch_ie = wbyte;
        IDX_PRE_CTL: s_next.pre_ctl = {wbyte[7], 3'h0, wbyte[3:0]};
        IDX_ACC_CTL: s_next.accumulator_enable_bit = wbyte[BIT_ACCUMULATOR_ENABLE_BIT];
        IDX_IRQ_EN:  s_next.ev_en = wbyte[3:0];
        default: begin
          // Other indices hold no state here
        end
      endcase
    end
    // Flags: a set in the clearing cycle wins
    s_next.ch_flag  = (s_reg.ch_flag & ~ch_clr) | ch_set;
    s_next.ovf_flag = (s_reg.ovf_flag & ~ovf_clr) | ovf_set;
    // Prescaler runs while the timer is enabled
    if (s_reg.timer_enable_bit) begin
      s_next.pre_cnt = s_reg.pre_cnt + 7'h01;
    end else begin
      s_next.pre_cnt = PRE_ZERO;
    end
    // Pending select adopted only with all stages zero
    if (s_reg.pre_cnt == PRE_ZERO) begin
      s_next.pre_sel = s_reg.pre_ctl[2:0];
    end
    // Counter
    if (s_reg.timer_enable_bit && tick) begin
      if (match_rst) begin
        s_next.counter = CNT_ZERO;
      end else begin
        s_next.counter = s_reg.counter + 16'h0001;
      end
    end
    // Pins and capture strobes
    s_next.pin_prev = cap_pin_i;
    s_next.cap_evt  = cap_now;
    // Sticky events, set wins over clear
    if (wr_do && idx == IDX_IRQ_CLR) begin
      s_next.ev_stat = (s_reg.ev_stat & ~wbyte[3:0]) | ev_in;
    end else begin
      s_next.ev_stat = s_reg.ev_stat | ev_in;
    end
    // Interrupt level from the next flag values
    s_next.irq = (|(s_next.ch_flag & s_next.ch_ie))
               | (s_next.ovf_flag & s_next.pre_ctl[BIT_TOI])
               | (|(s_next.ev_stat & s_next.ev_en));
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flip-flops
  assign dat_o           = {24'h000000, s_reg.rdata};
  assign ack_o           = s_reg.ack;
  assign capture_event_o = s_reg.cap_evt;
  assign counter_o       = s_reg.counter;
  assign timer_enable_o  = s_reg.timer_enable_bit;
  assign acc_enable_o    = s_reg.accumulator_enable_bit;
  assign irq_o           = s_reg.irq;

  // Checks
  sequence s_rise_seen(int n);
    s_reg.timer_enable_bit && chan_is_capture_i[n] && !s_reg.pin_prev[n] && cap_pin_i[n];
  endsequence

  // Falling edge seen on one channel
  sequence s_fall_seen(int n);
    s_reg.timer_enable_bit && chan_is_capture_i[n] && s_reg.pin_prev[n] && !cap_pin_i[n];
  endsequence

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held more than one cycle");

  a_rise_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise_seen(0) ##0 (s_reg.edge_cfg[1:0] == 2'b01) |=> capture_event_o[0] && s_reg.ch_flag[0])
    else $error("rising edge missed on channel 0");

  a_off_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_reg.edge_cfg[1:0] == 2'b00) |=> !capture_event_o[0]) else $error("capture while disabled");

  a_chan_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    |(s_reg.ch_flag & s_reg.ch_ie) |-> irq_o) else $error("channel interrupt missing");

  a_ovf_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.ovf_flag && s_reg.pre_ctl[BIT_TOI] |-> irq_o) else $error("overflow interrupt missing");

  a_match_reset: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.timer_enable_bit && tick && match_rst |=> counter_o == CNT_ZERO) else $error("match reset missed");

  a_zero_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.pre_ctl[BIT_COUNTER_RESET_ON_MATCH_ENABLE] && ch7_compare_i == CNT_ZERO && counter_o == CNT_ZERO
    ##1 ch7_compare_i == CNT_ZERO |-> counter_o == CNT_ZERO) else $error("counter left zero");

  a_max_noovf: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.timer_enable_bit && tick && match_rst && !s_reg.ovf_flag && counter_o == CNT_MAX && !(|compare_event_i)
    |=> !s_reg.ovf_flag) else $error("overflow set on match reset");

  a_presel_sync: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.pre_sel != $past(s_reg.pre_sel) |-> $past(s_reg.pre_cnt) == PRE_ZERO)
    else $error("prescale changed mid count");

  a_clr_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_do && idx == IDX_CH_FLAG && !clr_ok && s_reg.ch_flag[0] |=> s_reg.ch_flag[0])
    else $error("flag cleared while disabled");

  a_w1c_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_do && idx == IDX_CH_FLAG && clr_ok && wbyte[0] && !ch_set[0] |=> !s_reg.ch_flag[0])
    else $error("write one did not clear");

  a_fast_cnt: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.ffca && cnt_acc && !ovf_set |=> !s_reg.ovf_flag) else $error("counter access kept overflow");

  a_roll_ovf: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.timer_enable_bit && tick && counter_o == CNT_MAX && !match_rst |=> s_reg.ovf_flag && counter_o == CNT_ZERO)
    else $error("rollover missed");

  a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.timer_enable_bit && tick && !match_rst |=> counter_o == 16'($past(counter_o) + 16'h0001))
    else $error("counter did not step");

  // Falling edge with falling-only field
  a_fall_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fall_seen(0) ##0 (s_reg.edge_cfg[1:0] == 2'b10) |=> capture_event_o[0] && s_reg.ch_flag[0])
    else $error("falling edge missed on channel 0");

  // Falling edge ignored by rising-only field
  a_fall_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    s_fall_seen(0) ##0 (s_reg.edge_cfg[1:0] == 2'b01) |=> !capture_event_o[0])
    else $error("falling edge captured on rising field");

  // Either edge with both bits set
  a_any_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.timer_enable_bit && chan_is_capture_i[0] && (s_reg.edge_cfg[1:0] == 2'b11)
    && (s_reg.pin_prev[0] != cap_pin_i[0]) |=> capture_event_o[0])
    else $error("any edge missed on channel 0");

  // No enabled source, no interrupt
  a_irq_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|(s_reg.ch_flag & s_reg.ch_ie)) && !(s_reg.ovf_flag && s_reg.pre_ctl[BIT_TOI])
    && !(|(s_reg.ev_stat & s_reg.ev_en)) |-> !irq_o)
    else $error("interrupt without enabled source");

  // Free run without the match reset
  a_free_run: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.timer_enable_bit && tick && !s_reg.pre_ctl[BIT_COUNTER_RESET_ON_MATCH_ENABLE] && (counter_o != CNT_MAX) |=> counter_o != CNT_ZERO)
    else $error("counter reset while free running");

  // Select held while the stages count
  a_presel_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.pre_cnt != PRE_ZERO |=> $stable(s_reg.pre_sel))
    else $error("prescale select moved mid count");

  // Compare pulse sets its flag
  a_cmp_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    compare_event_i[0] |=> s_reg.ch_flag[0])
    else $error("compare did not set flag 0");

  // Writing zero keeps a channel flag
  a_w0_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_do && (idx == IDX_CH_FLAG) && !wbyte[0] && s_reg.ch_flag[0] |=> s_reg.ch_flag[0])
    else $error("zero write cleared flag 0");

  // Writing zero keeps the overflow flag
  a_ovf_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_do && (idx == IDX_OVF_FLAG) && !wbyte[BIT_OVF] && s_reg.ovf_flag |=> s_reg.ovf_flag)
    else $error("zero write cleared overflow");

  // Channel access fast clear
  a_fast_chan: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.ffca && bus_do && ch_acc && (chan_is_capture_i[ch_num] ? !we_i : we_i) && !ch_set[ch_num]
    |=> !s_reg.ch_flag[$past(ch_num)])
    else $error("channel access did not clear flag");

  // Clearing with the accumulator enable alone
  a_acc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_do && (idx == IDX_CH_FLAG) && !s_reg.timer_enable_bit && s_reg.accumulator_enable_bit && wbyte[1] && !ch_set[1]
    |=> !s_reg.ch_flag[1])
    else $error("accumulator enable did not allow clear");

  // Precision mode counts external ticks only
  a_prec_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    s_reg.precision_timer_select && !precision_tick_i |=> $stable(counter_o))
    else $error("counter moved without precision tick");

  // Disabled timer freezes the counter
  a_ten_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_reg.timer_enable_bit |=> $stable(counter_o))
    else $error("counter moved while disabled");

  // Bus answer one cycle after the request
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");

endmodule // tcfc_timer
`default_nettype wire

// >>> tcfc_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// Far side: capture pin sources and external comparators
module tcfc_pin_model (
  input  wire logic       clk_i, // Bus clock
  input  wire logic       rst_i, // Synchronous reset
  input  wire logic [7:0] tog_i, // Pins to toggle at next edge
  input  wire logic [7:0] hit_i, // Compare hits to pulse
  output logic      [7:0] pin_o, // Capture pin levels
  output logic      [7:0] hit_o  // One-cycle compare pulses
);
  // Levels change just after an edge and then hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o <= 8'h00;
      hit_o <= 8'h00;
    end else begin
      pin_o <= pin_o ^ tog_i;
      hit_o <= hit_i;
    end
  end
endmodule // tcfc_pin_model
`default_nettype wire

// >>> tcfc_timer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tcfc_timer_tb_top;
  import tcfc_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, ten_o, acc_o, ptick;
  logic [7:0]  adr_i, tog, hit, pins, cmp, cap_mode, cap_ev, rd, exp8, mask, cap_seen;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, seed;
  logic [15:0] ch7, counter_o, c0, mx;
  int          bad_count, checks, n;   // Mismatch and comparison counters

  tcfc_timer tcfc_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cap_pin_i(pins),
    .chan_is_capture_i(cap_mode), .compare_event_i(cmp), .ch7_compare_i(ch7), .precision_tick_i(ptick),
    .capture_event_o(cap_ev), .counter_o(counter_o), .timer_enable_o(ten_o), .acc_enable_o(acc_o),
    .irq_o(irq_o));
  tcfc_pin_model tcfc_pin_model_inst (.clk_i(clk_i), .rst_i(rst_i), .tog_i(tog), .hit_i(hit),
    .pin_o(pins), .hit_o(cmp));

  // Free-running 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] q);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, wd};
    sel_i <= 4'h1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] want);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk({8'h00, d}, {8'h00, want});
  endtask

  // Toggle pins or pulse comparators for one cycle, then let flags land
  task automatic kick(input logic [7:0] t, input logic [7:0] h);
    tog <= t;
    hit <= h;
    @(posedge clk_i);
    tog <= 8'h00;
    hit <= 8'h00;
    repeat (2) @(posedge clk_i);
    cap_seen = cap_ev; // Strobe stands one cycle after the edge is seen
    repeat (2) @(posedge clk_i);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog sized above the single counter rollover
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    conclude();
  end

  initial begin
    logic [5:0] regs [7] = '{IDX_EDGE_UP, IDX_EDGE_LO, IDX_CH_IE, IDX_PRE_CTL, IDX_CH_FLAG, IDX_OVF_FLAG, 6'h3f};
    logic [2:0] pre [3] = '{3'h0, 3'h3, 3'h7};
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h0; dat_i = 32'h0;
    tog = 8'h00; hit = 8'h00; cap_mode = 8'hff; ch7 = 16'hffff; seed = 32'h00008ccf;
    ptick = 1'b0;
    cap_seen = 8'h00;
    bad_count = 0; checks = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (regs[i]) rdc(regs[i], 8'h00);
    // Prescale ratios: counts over a window of whole periods
    wr(IDX_SYS_CTL, 8'h80);
    foreach (pre[i]) begin
      wr(IDX_PRE_CTL, {5'h00, pre[i]});
      repeat (300) @(posedge clk_i);
      c0 = counter_o;
      repeat (256) @(posedge clk_i);
      chk(counter_o - c0, 16'(256 >> pre[i]));
    end
    // All four edge codes on channels 3..0, upper channels off
    for (int c = 0; c < 4; c++) begin
      wr(IDX_EDGE_LO, 8'(c * 8'h55));
      wr(IDX_EDGE_UP, 8'h00);
      seed = xs(seed);
      mask = seed[7:0];
      exp8 = (c[0]) ? (mask & 8'h0f) : 8'h00;
      kick(mask, 8'h00);
      chk({8'h00, cap_seen}, {8'h00, exp8});
      rdc(IDX_CH_FLAG, exp8);
      wr(IDX_CH_IE, seed[15:8]);
      repeat (2) @(posedge clk_i);
      chk({15'h0, irq_o}, {15'h0, |(exp8 & seed[15:8])});
      wr(IDX_CH_IE, 8'h00);
      wr(IDX_CH_FLAG, 8'hff);
      exp8 = (c[1]) ? (mask & 8'h0f) : 8'h00;
      kick(mask, 8'h00);
      chk({8'h00, cap_seen}, {8'h00, exp8});
      rdc(IDX_CH_FLAG, exp8);
      wr(IDX_CH_FLAG, 8'hff);
    end
    // Write-one clear and its enable gating
    cap_mode <= 8'h04;
    kick(8'h00, 8'h0f);
    rdc(IDX_CH_FLAG, 8'h0f);
    wr(IDX_CH_FLAG, 8'h00);
    rdc(IDX_CH_FLAG, 8'h0f);
    wr(IDX_CH_FLAG, 8'h01);
    rdc(IDX_CH_FLAG, 8'h0e);
    wr(IDX_SYS_CTL, 8'h00);
    wr(IDX_CH_FLAG, 8'h02);
    rdc(IDX_CH_FLAG, 8'h0e);
    wr(IDX_ACC_CTL, 8'h40);
    chk({14'h0, acc_o, ten_o}, 16'h0002);
    wr(IDX_CH_FLAG, 8'h02);
    rdc(IDX_CH_FLAG, 8'h0c);
    wr(IDX_ACC_CTL, 8'h00);
    // Fast clear: capture read clears, compare read does not, compare write does
    wr(IDX_SYS_CTL, 8'h90);
    bus(1'b0, 6'h14, 8'h00, rd);
    bus(1'b0, 6'h16, 8'h00, rd);
    rdc(IDX_CH_FLAG, 8'h08);
    wr(6'h16, 8'h00);
    rdc(IDX_CH_FLAG, 8'h00);
    cap_mode <= 8'hff;
    // Rollover, event interrupt, overflow interrupt, fast clear on counter access
    wr(IDX_PRE_CTL, 8'h00);
    wr(IDX_IRQ_CLR, 8'h0f);
    n = 0;
    while (counter_o !== 16'hffff && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (2) @(posedge clk_i);
    rdc(IDX_OVF_FLAG, 8'h80);
    rdc(IDX_IRQ_STAT, 8'h01);
    wr(IDX_OVF_FLAG, 8'h7f);
    rdc(IDX_OVF_FLAG, 8'h80);
    wr(IDX_IRQ_EN, 8'h01);
    chk({15'h0, irq_o}, 16'h0001);
    wr(IDX_IRQ_CLR, 8'h01);
    chk({15'h0, irq_o}, 16'h0000);
    wr(IDX_IRQ_EN, 8'h00);
    wr(IDX_PRE_CTL, 8'h80);
    chk({15'h0, irq_o}, 16'h0001);
    bus(1'b0, IDX_CNT_HI, 8'h00, rd);
    rdc(IDX_OVF_FLAG, 8'h00);
    chk({15'h0, irq_o}, 16'h0000);
    // Match reset: modulus run, then a zero compare pins the counter
    ch7 <= 16'h0400;
    wr(IDX_PRE_CTL, 8'h08);
    mx = 16'h0000;
    repeat (2100) begin
      @(posedge clk_i);
      if (counter_o > mx) mx = counter_o;
    end
    chk(mx, 16'h0400);
    n = 0;
    while (counter_o !== 16'h0400 && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    ch7 <= 16'h0000;
    repeat (3) @(posedge clk_i);
    mx = 16'h0000;
    repeat (40) begin
      @(posedge clk_i);
      if (counter_o > mx) mx = counter_o;
    end
    chk(mx, 16'h0000);
    // Second reset, then precision mode: only the external tick counts
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(counter_o, 16'h0000);
    wr(IDX_SYS_CTL, 8'h88);
    // Legacy select is zero, which would tick every cycle
    for (int t = 0; t < 6; t++) begin
      ptick <= 1'b1;
      @(posedge clk_i);
      ptick <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    chk(counter_o, 16'h0006);
    conclude();
  end
endmodule // tcfc_timer_tb_top
`default_nettype wire
